// [inc/meas_ctrl_map.svh]
// Address map, reset values and widths of the measurement control block.
// Assumes it is included by the package and by any file that needs a
// figure; it holds definitions only.
`ifndef MEAS_CTRL_MAP_SVH
`define MEAS_CTRL_MAP_SVH

// Register port widths
`define REG_ADDR_W 4
`define REG_DATA_W 16

// Word addresses on the register port
`define CTRL_ADDR 4'h0
`define SAMPLE_CNT_ADDR 4'h4
`define CLK_STAT_ADDR 4'h8

// Control word reset value and writable bits (bit 7 is reserved)
`define CTRL_RESET 16'h0000
`define CTRL_WMASK 16'hff7f

// Receive gain code width and number of receive clock sources
`define GAIN_W 8
`define RX_SRC_N 4

// Sample edge counter
`define SAMPLE_CNT_RESET 16'h0000
`define SAMPLE_CNT_STEP 16'h0001

`endif

// [inc/meas_ctrl_pkg.sv]
// Types shared by the measurement control register and its clock selector.
// Assumes meas_ctrl_map.svh is on the include path.
`include "meas_ctrl_map.svh"

package meas_ctrl_pkg;

  // Receive sample clock rates, in source order on the clock input vector
  typedef enum logic [1:0] {
    RX_CLK_97K2,
    RX_CLK_160K,
    RX_CLK_153K6,
    RX_CLK_1M
  } rx_clk_sel_type;

  // Receive converter input choice
  typedef enum logic {
    ADC_FROM_RECEIVER_IF,
    ADC_FROM_POWER_METER
  } adc_input_type;

  // Control word layout, most significant field first
  typedef struct packed {
    logic [`GAIN_W-1:0] gain_code;
    logic reserved;
    logic gain_source_select;
    logic generator_direction_select;
    logic reflection_test_mode;
    logic incident_reflected_select;
    adc_input_type adc_input;
    rx_clk_sel_type rx_clk_sel;
  } ctrl_type;

  // Measurement control lines towards the RF boards
  typedef struct packed {
    adc_input_type adc_input;
    logic incident_reflected_select;
    logic reflection_test_mode;
    logic generator_direction_select;
    logic gain_source_select;
  } meas_ctrl_type;

  // Clock status word
  typedef struct packed {
    logic [12:0] reserved;
    logic switching;
    rx_clk_sel_type active;
  } clk_stat_type;

  // Clock selector sequencing
  typedef enum logic [1:0] {
    SEL_RUN,
    SEL_DRAIN,
    SEL_ARM
  } sel_state_type;

  typedef struct packed {
    sel_state_type state;
    rx_clk_sel_type active;
    logic clk_out;
    logic edge_seen;
  } sel_type;

  // Whole state of the register block
  typedef struct packed {
    ctrl_type ctrl;
    logic [`REG_DATA_W-1:0] sample_cnt;
    logic [`REG_DATA_W-1:0] rdata;
    logic gain_load;
  } regs_type;

endpackage

// [src/rx_clock_select.sv]
// Glitch-free selector for the receive sample clock.
// Assumes the source clock levels are synchronous to i_sys_clk.
`timescale 1ns/1ns
`include "meas_ctrl_map.svh"

module rx_clock_select (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Sources and choice
  input wire logic [`RX_SRC_N-1:0] i_rx_clk_src,
  input wire meas_ctrl_pkg::rx_clk_sel_type i_select,
  // Selected clock and status
  output logic o_rx_clk,
  output logic o_rx_edge,
  output meas_ctrl_pkg::rx_clk_sel_type o_active,
  output logic o_switching
);
  import meas_ctrl_pkg::*;

  sel_type sel_reg;
  sel_type sel_next;

  // Switching only while both clocks are low avoids runt pulses that
  // would give the converter a short sample period
  always_comb begin
    sel_next = sel_reg;
    unique case (sel_reg.state)
      SEL_RUN: begin
        sel_next.clk_out = i_rx_clk_src[sel_reg.active];
        if (i_select != sel_reg.active) begin
          sel_next.state = SEL_DRAIN;
        end
      end
      SEL_DRAIN: begin
        // Let the old clock finish its high phase
        sel_next.clk_out = i_rx_clk_src[sel_reg.active];
        if (!i_rx_clk_src[sel_reg.active]) begin
          sel_next.state = SEL_ARM;
        end
      end
      SEL_ARM: begin
        // Hold low until the new source is low too
        sel_next.clk_out = 1'b0;
        if (!i_rx_clk_src[i_select]) begin
          sel_next.active = i_select;
          sel_next.state = SEL_RUN;
        end
      end
      default: begin
        // Unused state code: fall back to following the active source
        sel_next.state = SEL_RUN;
      end
    endcase
    sel_next.edge_seen = sel_next.clk_out & ~sel_reg.clk_out;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_reg <= '{SEL_RUN, RX_CLK_97K2, 1'b0, 1'b0};
    end else begin
      sel_reg <= sel_next;
    end
  end

  assign o_rx_clk = sel_reg.clk_out;
  assign o_rx_edge = sel_reg.edge_seen;
  assign o_active = sel_reg.active;
  assign o_switching = sel_reg.state != SEL_RUN;

endmodule

// [src/measurement_control_register.sv]
// Measurement control register written by the signal processor.
// Assumes a one-cycle register port in the i_sys_clk domain and receive
// clock sources that are already synchronous to i_sys_clk.
//
// Summary of operation
// - One 16-bit processor-written control word governs clock, lines, gain.
// - One control bit picks receiver IF or power meter for the converter.
// - Incident/reflected line high for incident, low for reflected power.
// - Reflection test line low for normal receive, high for test mode.
// - Generator direction line low for forward, high for reverse channels.
// - The 8-bit gain code is held and driven to the gain DAC always.
// - Gain source line low for register gain, high for receiver AGC.
// - The clock field picks 97.2 kHz, 160 kHz, 153.6 kHz or 1 MHz.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "meas_ctrl_map.svh"

module measurement_control_register #(
  parameter int ADDR_W = `REG_ADDR_W,
  parameter int DATA_W = `REG_DATA_W
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [DATA_W-1:0] o_reg_rdata,
  // Receive clock sources, in rx_clk_sel_type order
  input wire logic [`RX_SRC_N-1:0] i_rx_clk_src,
  // Receive sample clock
  output logic o_rx_clk,
  // Measurement control lines
  output meas_ctrl_pkg::meas_ctrl_type o_meas_ctrl,
  // Receive gain DAC
  output logic [`GAIN_W-1:0] o_rx_gain_code,
  output logic o_gain_dac_load
);
  import meas_ctrl_pkg::*;

  regs_type regs_reg;
  regs_type regs_next;

  logic rx_edge;
  logic rx_switching;
  rx_clk_sel_type rx_active;
  clk_stat_type clk_stat;

  // Full-word decode; the port has no byte lanes
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] base);
    hit = addr == base;
  endfunction

  // Receive sample clock selection and its switch-over
  rx_clock_select u_rx_clock_select (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_rx_clk_src(i_rx_clk_src),
    .i_select(regs_reg.ctrl.rx_clk_sel),
    .o_rx_clk(o_rx_clk),
    .o_rx_edge(rx_edge),
    .o_active(rx_active),
    .o_switching(rx_switching)
  );

  // Status word read back by software
  always_comb begin
    clk_stat = '0;
    clk_stat.switching = rx_switching;
    clk_stat.active = rx_active;
  end

  // Next state of the register file
  always_comb begin
    regs_next = regs_reg;
    regs_next.rdata = '0;
    regs_next.gain_load = 1'b0;

    // Control word write; the reserved bit stays zero
    if (i_reg_wr && hit(i_reg_addr, ADDR_W'(`CTRL_ADDR))) begin
      regs_next.ctrl = ctrl_type'(i_reg_wdata & DATA_W'(`CTRL_WMASK));
      // Pulse the DAC load only when the code really moves
      regs_next.gain_load =
        regs_next.ctrl.gain_code != regs_reg.ctrl.gain_code;
    end

    // Sample edge counter; an edge in the clearing cycle still counts
    if (i_reg_wr && hit(i_reg_addr, ADDR_W'(`SAMPLE_CNT_ADDR))) begin
      regs_next.sample_cnt = DATA_W'(`SAMPLE_CNT_RESET);
    end
    if (rx_edge) begin
      regs_next.sample_cnt = regs_next.sample_cnt +
                             DATA_W'(`SAMPLE_CNT_STEP);
    end

    // Read data stand in the cycle after the strobe only
    if (i_reg_rd) begin
      if (hit(i_reg_addr, ADDR_W'(`CTRL_ADDR))) begin
        regs_next.rdata = DATA_W'(regs_reg.ctrl);
      end else if (hit(i_reg_addr, ADDR_W'(`SAMPLE_CNT_ADDR))) begin
        regs_next.rdata = regs_reg.sample_cnt;
      end else if (hit(i_reg_addr, ADDR_W'(`CLK_STAT_ADDR))) begin
        regs_next.rdata = DATA_W'(clk_stat);
      end else begin
        regs_next.rdata = '0; // Unmapped reads return zero
      end
    end
  end

  // State register; reset leaves normal receive and register gain
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      regs_reg.ctrl <= ctrl_type'(`CTRL_RESET);
      regs_reg.sample_cnt <= `SAMPLE_CNT_RESET;
      regs_reg.rdata <= '0;
      regs_reg.gain_load <= 1'b0;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // Control lines straight from the register bits, free of decode glitches
  always_comb begin
    o_meas_ctrl.adc_input = regs_reg.ctrl.adc_input;
    o_meas_ctrl.incident_reflected_select =
      regs_reg.ctrl.incident_reflected_select;
    o_meas_ctrl.reflection_test_mode =
      regs_reg.ctrl.reflection_test_mode;
    o_meas_ctrl.generator_direction_select =
      regs_reg.ctrl.generator_direction_select;
    o_meas_ctrl.gain_source_select =
      regs_reg.ctrl.gain_source_select;
  end

  // Gain code is held even while the receiver AGC governs gain
  assign o_rx_gain_code = regs_reg.ctrl.gain_code;
  assign o_gain_dac_load = regs_reg.gain_load;
  assign o_reg_rdata = regs_reg.rdata;

endmodule

// [verification/meas_ctrl_sva.sv]
// Port assertions for the measurement control register.
// Assumes meas_ctrl_pkg is compiled first; bound into every instance.
`timescale 1ns/1ns
`include "meas_ctrl_map.svh"
module meas_ctrl_sva
  import meas_ctrl_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [DATA_W-1:0] o_reg_rdata,
  input wire logic [`RX_SRC_N-1:0] i_rx_clk_src,
  input wire logic o_rx_clk,
  input wire meas_ctrl_type o_meas_ctrl,
  input wire logic [`GAIN_W-1:0] o_rx_gain_code,
  input wire logic o_gain_dac_load
);
  logic wr0;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // Only a control write may move the lines
  assign wr0 = i_reg_wr && i_reg_addr == 0;
  sequence s_gain_wr;
    wr0 && i_reg_wdata[15:8] != o_rx_gain_code;
  endsequence
  sequence s_rd0;
    i_reg_rd && i_reg_addr == 0;
  endsequence
  AST_ADC: assert property (wr0 |=>
    o_meas_ctrl.adc_input == $past(i_reg_wdata[2])) else $error("adc");
  AST_LINES: assert property (wr0 |=> o_meas_ctrl[3:0] ==
    $past({i_reg_wdata[3], i_reg_wdata[4], i_reg_wdata[5], i_reg_wdata[6]}))
    else $error("lines");
  AST_GAIN: assert property (wr0 |=>
    o_rx_gain_code == $past(i_reg_wdata[15:8])) else $error("gain");
  AST_LOAD: assert property (s_gain_wr |=> o_gain_dac_load)
    else $error("load");
  AST_NOLOAD: assert property (!wr0 |=> !o_gain_dac_load)
    else $error("noload");
  AST_HOLD: assert property (!wr0 |=> $stable(o_meas_ctrl) &&
    $stable(o_rx_gain_code)) else $error("hold");
  AST_RST: assert property ($rose(i_resetn) |->
    o_meas_ctrl == 0 && o_rx_gain_code == 0) else $error("reset");
  AST_RDCTRL: assert property (s_rd0 |=>
    o_reg_rdata[15:7] == {$past(o_rx_gain_code), 1'b0}) else $error("rd");
  // Read data stand only in the cycle after a read strobe
  AST_RDIDLE: assert property (!i_reg_rd |=> o_reg_rdata == '0)
    else $error("rdidle");
endmodule

bind measurement_control_register meas_ctrl_sva #(.ADDR_W(ADDR_W),
  .DATA_W(DATA_W)) u_sva (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_rx_clk_src(i_rx_clk_src), .o_rx_clk(o_rx_clk),
  .o_meas_ctrl(o_meas_ctrl), .o_rx_gain_code(o_rx_gain_code),
  .o_gain_dac_load(o_gain_dac_load));

// [verification/fp_processor_model.sv]
// Signal processor side of the register port.
// Assumes each call starts at a rising edge of i_sys_clk.
`timescale 1ns/1ns
module fp_processor_model (
  input wire logic i_sys_clk,
  input wire logic [15:0] i_rdata,
  output logic [3:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 4'h0;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // The strobe stands for one edge and is lowered before the call
  // returns, so no signal is assigned twice in one time step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    o_rd <= 1'b0;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  // Read data stand only in the cycle after the read edge, so they are
  // taken at the next edge, before the slave clears them
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    o_addr <= a;
    o_wr <= 1'b0;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    @(posedge i_sys_clk);
    d = i_rdata;
  endtask
  // Released bus shows no stale value
  task automatic idle();
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~o_addr;
    o_wdata <= ~o_wdata;
    @(posedge i_sys_clk);
  endtask
endmodule

// [verification/measurement_control_register_tb.sv]
// Self-checking bench for the measurement control register.
// Assumes the package, design, checker and processor model are compiled.
`timescale 1ns/1ns
module measurement_control_register_tb;
  import meas_ctrl_pkg::*;
  logic clk, rst_n, wr, rd, rx_clk, load;
  logic [3:0] addr, src, src_d;
  logic [4:0] cnt;
  logic [15:0] wdata, rdata, d, exp_w;
  logic [7:0] gain, loads;
  meas_ctrl_type lines;
  int err_total, check_count;
  measurement_control_register dut (.i_sys_clk(clk), .i_resetn(rst_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_rx_clk_src(src), .o_rx_clk(rx_clk),
    .o_meas_ctrl(lines), .o_rx_gain_code(gain), .o_gain_dac_load(load));
  fp_processor_model host (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Four source clocks of different rates, plus a one-cycle delayed copy
  initial cnt = 5'h0;
  assign src = cnt[4:1];
  always @(posedge clk) begin
    cnt <= cnt + 5'h1;
    src_d <= src;
  end
  // Count gain DAC load pulses; each pulse stands for one cycle
  initial loads = 8'h00;
  always @(posedge clk) begin
    if (load)
      loads <= loads + 8'h01;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    host.rd(4'h0, d);
    chk(d, 16'h0000);
    host.wr(4'h0, 16'hffff);
    chk({3'h0, lines, gain}, 16'h1fff);
    host.rd(4'h0, d);
    chk(d, 16'hff7f);
    // Unmapped place: write dropped, read gives zero
    host.wr(4'h2, 16'h0000);
    chk({3'h0, lines, gain}, 16'h1fff);
    host.rd(4'h2, d);
    chk(d, 16'h0000);
    for (int i = 2; i < 7; i++) begin
      host.wr(4'h0, {8'h01 << i, 8'h01 << i});
      exp_w = (16'h0800 << (6 - i)) | (16'h0001 << i);
      chk({lines, 3'h0, gain}, exp_w);
    end
    for (int s = 3; s >= 0; s--) begin
      host.wr(4'h0, 16'(s));
      d = 16'hffff;
      for (int n = 0; n < 100 && d !== 16'(s); n++)
        host.rd(4'h8, d);
      chk(d, 16'(s));
      // Sampled before the edge's update, so both sides lag alike
      repeat (8) begin
        @(posedge clk);
        chk(16'(rx_clk), 16'(src_d[s]));
      end
    end
    // Only the first of the clock-select writes moved the gain code
    chk(16'(loads), 16'h0007);
    // Source 0 rises once in four cycles: a 16-edge window holds four
    host.wr(4'h4, 16'h00ff);
    repeat (14) @(posedge clk);
    host.rd(4'h4, d);
    chk(d, 16'h0004);
    // Reset in mid-run clears the word again
    host.wr(4'h0, 16'hff7f);
    chk({3'h0, lines, gain}, 16'h1fff);
    host.idle();
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({3'h0, lines, gain}, 16'h0000);
    host.rd(4'h0, d);
    chk(d, 16'h0000);
    summarize();
  end
endmodule
